// *** src/independent_watchdog_config.sv ***
/*
 * Independent watchdog with auto-start and register start modes.
 * Assumes the dedicated watchdog clock arrives as a slow pin level,
 * the option word is static, and low-power inputs are on mclk.
 */
// Local design decisions: the address-and-strobe port and the register addresses.
`default_nettype none
module independent_watchdog_config #(
    parameter bit LARGE_TIMEOUT = 1'b1
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wdt_clk_pin,
    input wire logic [31:0] opt_word,
    input wire logic sleep_mode,
    input wire logic sw_standby,
    input wire logic deep_low_power,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    output logic fault_reset,
    output logic fault_irq,
    output logic counting
);

    // ************************************************************
    // Decoding functions.
    // ************************************************************

    // Maps a timeout code to the counter load value of the variant.
    function automatic logic [13:0] load_of(input logic [1:0] timeout_field);
        logic [13:0] v;
        v = watchdog_pkg::LOAD_L0;
        if (LARGE_TIMEOUT) begin
            case (timeout_field)
                2'h0: v = watchdog_pkg::LOAD_L0;
                2'h1: v = watchdog_pkg::LOAD_L1;
                2'h2: v = watchdog_pkg::LOAD_L2;
                default: v = watchdog_pkg::LOAD_L3;
            endcase
        end else begin
            case (timeout_field)
                2'h0: v = watchdog_pkg::LOAD_S0;
                2'h1: v = watchdog_pkg::LOAD_S1;
                2'h2: v = watchdog_pkg::LOAD_S2;
                default: v = watchdog_pkg::LOAD_S3;
            endcase
        end
        return v;
    endfunction

    // Maps a divider code to a prescaler mask; unknown codes give 1.
    function automatic logic [7:0] div_mask(input logic [3:0] clock_divide_field);
        logic [7:0] m;
        m = 8'h00;
        case (clock_divide_field)
            watchdog_pkg::CKS_DIV1: m = 8'h00;
            watchdog_pkg::CKS_DIV16: m = 8'h0F;
            watchdog_pkg::CKS_DIV32: m = 8'h1F;
            watchdog_pkg::CKS_DIV64: m = 8'h3F;
            watchdog_pkg::CKS_DIV128: m = 8'h7F;
            watchdog_pkg::CKS_DIV256: m = 8'hFF;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    // Scales a quarter of the period by a factor of zero to four.
    function automatic logic [14:0] win_level(input logic [14:0] q,
                                              input logic [2:0] k);
        logic [17:0] p;
        p = q * k;
        return p[14:0];
    endfunction

    // ************************************************************
    // State and combinational helpers.
    // ************************************************************
    watchdog_pkg::wdt_state_t st_r; // All state of the block.
    watchdog_pkg::wdt_state_t st_nxt; // Next value of the state.
    watchdog_pkg::wdt_cfg_t opt_cfg; // Settings from the option word.
    watchdog_pkg::wdt_cfg_t reg_cfg; // Settings from the registers.
    logic refresh; // A complete refresh sequence this cycle.
    logic permitted; // Counter lies inside the refresh window.
    logic low_power; // The system is in any low-power mode.
    logic tick; // A counting edge of the dedicated clock.
    logic fault; // Underflow or refresh error this cycle.
    logic [14:0] quarter; // One quarter of the timeout period.

    assign rdata = st_r.rdata;
    assign fault_reset = st_r.fault_reset;
    assign fault_irq = st_r.fault_irq;
    assign counting = st_r.counting;

    // Gathers the boot settings from the option word.
    always_comb begin
        opt_cfg.clock_divide_field = st_r.opt_s2[watchdog_pkg::OPT_CKS_LSB +: 4];
        opt_cfg.timeout_field = st_r.opt_s2[watchdog_pkg::OPT_TIMEOUT_FIELD_LSB +: 2];
        opt_cfg.window_start_field = st_r.opt_s2[watchdog_pkg::OPT_WINDOW_START_FIELD_LSB +: 2];
        opt_cfg.window_end_field = st_r.opt_s2[watchdog_pkg::OPT_WINDOW_END_FIELD_LSB +: 2];
        opt_cfg.rst_sel = st_r.opt_s2[watchdog_pkg::OPT_RST_BIT];
        opt_cfg.stp = st_r.opt_s2[watchdog_pkg::OPT_STP_BIT];
    end

    // Gathers the runtime settings from the control registers.
    always_comb begin
        reg_cfg.clock_divide_field = st_r.ctrl[watchdog_pkg::CR_CKS_LSB +: 4];
        reg_cfg.timeout_field = st_r.ctrl[watchdog_pkg::CR_TIMEOUT_FIELD_LSB +: 2];
        reg_cfg.window_start_field = st_r.ctrl[watchdog_pkg::CR_WINDOW_START_FIELD_LSB +: 2];
        reg_cfg.window_end_field = st_r.ctrl[watchdog_pkg::CR_WINDOW_END_FIELD_LSB +: 2];
        reg_cfg.rst_sel = st_r.fault_sel;
        reg_cfg.stp = st_r.stop_sel;
    end

    // Window test: start code 3 opens at once, end code 3 closes at 0.
    always_comb begin
        quarter = ({1'b0, load_of(st_r.eff.timeout_field)} + 15'h0001) >> 2;
        permitted = (st_r.cnt <
            win_level(quarter, {1'b0, st_r.eff.window_start_field} + 3'h1))
            && (st_r.cnt >= win_level(quarter,
            3'h3 - {1'b0, st_r.eff.window_end_field}));
    end

    // Low-power stop gate and the undivided counting tick.
    always_comb begin
        low_power = sleep_mode | sw_standby | deep_low_power;
        tick = st_r.clk_s2 & ~st_r.clk_s3
            & ~(st_r.eff.stp & low_power);
    end

    // ************************************************************
    // Next-state logic.
    // ************************************************************
    always_comb begin
        st_nxt = st_r;
        refresh = 1'b0;
        fault = 1'b0;
        // Outputs that pulse drop back after one cycle.
        st_nxt.fault_reset = 1'b0;
        st_nxt.fault_irq = 1'b0;
        st_nxt.rdata = 16'h0000;
        // Two-stage synchronisers for the pin clock and option word.
        st_nxt.clk_s1 = wdt_clk_pin;
        st_nxt.clk_s2 = st_r.clk_s1;
        st_nxt.clk_s3 = st_r.clk_s2;
        st_nxt.opt_s1 = opt_word;
        st_nxt.opt_s2 = st_r.opt_s1;

        // Read data stands in the cycle after the strobe.
        if (rd_stb) begin
            case (addr)
                watchdog_pkg::OFF_CONTROL: st_nxt.rdata = st_r.ctrl;
                watchdog_pkg::OFF_FAULT:
                    st_nxt.rdata = {8'h00, st_r.fault_sel, 7'h00};
                watchdog_pkg::OFF_STOP:
                    st_nxt.rdata = {8'h00, st_r.stop_sel, 7'h00};
                watchdog_pkg::OFF_STATUS:
                    st_nxt.rdata = {st_r.re_flag, st_r.uf_flag, st_r.cnt};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end

        // Refresh byte pair; any other byte breaks the sequence.
        if (wr_stb && addr == watchdog_pkg::OFF_REFRESH) begin
            refresh = st_r.seen_first
                && wdata[7:0] == watchdog_pkg::REFRESH_SECOND;
            st_nxt.seen_first = wdata[7:0] == watchdog_pkg::REFRESH_FIRST;
        end

        // Settings are writable only in register mode before start.
        if (wr_stb && !st_r.auto_mode && !st_r.started
            && st_r.fsm == watchdog_pkg::ST_IDLE) begin
            case (addr)
                watchdog_pkg::OFF_CONTROL: st_nxt.ctrl = wdata;
                watchdog_pkg::OFF_FAULT:
                    st_nxt.fault_sel = wdata[watchdog_pkg::FAULT_SEL_BIT];
                watchdog_pkg::OFF_STOP:
                    st_nxt.stop_sel = wdata[watchdog_pkg::STOP_SEL_BIT];
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end

        // Writing a one clears a flag; a same-cycle event sets it again.
        if (wr_stb && addr == watchdog_pkg::OFF_STATUS) begin
            if (wdata[watchdog_pkg::UF_BIT]) begin
                st_nxt.uf_flag = 1'b0;
            end
            if (wdata[watchdog_pkg::RE_BIT]) begin
                st_nxt.re_flag = 1'b0;
            end
        end

        case (st_r.fsm)
            watchdog_pkg::ST_BOOT: begin
                // Captures the option word once it has settled.
                if (st_r.wait_cnt == watchdog_pkg::BOOT_WAIT) begin
                    st_nxt.auto_mode =
                        ~st_r.opt_s2[watchdog_pkg::OPT_MODE_BIT];
                    if (st_nxt.auto_mode) begin
                        st_nxt.eff = opt_cfg;
                        st_nxt.cnt = load_of(opt_cfg.timeout_field);
                        st_nxt.pre = 8'h00;
                        st_nxt.counting = 1'b1;
                        st_nxt.fsm = watchdog_pkg::ST_COUNT;
                    end else begin
                        st_nxt.fsm = watchdog_pkg::ST_IDLE;
                    end
                end else begin
                    st_nxt.wait_cnt = st_r.wait_cnt + 2'h1;
                end
            end
            watchdog_pkg::ST_IDLE: begin
                // A refresh latches the register settings and starts.
                if (refresh) begin
                    st_nxt.eff = reg_cfg;
                    st_nxt.cnt = load_of(reg_cfg.timeout_field);
                    st_nxt.pre = 8'h00;
                    st_nxt.started = 1'b1;
                    st_nxt.counting = 1'b1;
                    st_nxt.fsm = watchdog_pkg::ST_COUNT;
                end
            end
            watchdog_pkg::ST_COUNT: begin
                if (refresh) begin
                    if (permitted) begin
                        st_nxt.cnt = load_of(st_r.eff.timeout_field);
                        st_nxt.pre = 8'h00;
                    end else begin
                        st_nxt.re_flag = 1'b1;
                        fault = 1'b1;
                    end
                end else if (tick) begin
                    // Prescaler rolls over at the selected ratio.
                    st_nxt.pre = st_r.pre + 8'h01;
                    if ((st_r.pre & div_mask(st_r.eff.clock_divide_field))
                        == div_mask(st_r.eff.clock_divide_field)) begin
                        if (st_r.cnt == 14'h0000) begin
                            st_nxt.uf_flag = 1'b1;
                            fault = 1'b1;
                        end else begin
                            st_nxt.cnt = st_r.cnt - 14'h0001;
                        end
                    end
                end
                // A fault fires the chosen output and stops the count, except an interrupt in auto-start mode, which reloads it.
                if (fault) begin
                    st_nxt.pre = 8'h00;
                    if (st_r.eff.rst_sel) begin
                        st_nxt.fault_reset = 1'b1;
                        st_nxt.counting = 1'b0;
                        st_nxt.fsm = watchdog_pkg::ST_HALT;
                    end else begin
                        st_nxt.fault_irq = 1'b1;
                        if (st_r.auto_mode) begin
                            st_nxt.cnt = load_of(st_r.eff.timeout_field);
                        end else begin
                            st_nxt.counting = 1'b0;
                            st_nxt.fsm = watchdog_pkg::ST_IDLE;
                        end
                    end
                end
            end
            watchdog_pkg::ST_HALT: begin
                // Stays stopped until the system reset arrives.
                st_nxt.counting = 1'b0;
            end
            default: begin
                st_nxt.fsm = watchdog_pkg::ST_BOOT;
            end
        endcase
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= watchdog_pkg::STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule
`default_nettype wire

// *** src/watchdog_pkg.sv ***
/*
 * Constants and types of the independent watchdog configuration block.
 * Assumes a single 100 MHz system clock and a static option word.
 */
`default_nettype none
package watchdog_pkg;

    // ************************************************************
    // Register offsets on the plain register port.
    // ************************************************************
    localparam logic [3:0] OFF_REFRESH = 4'h0; // Refresh register.
    localparam logic [3:0] OFF_CONTROL = 4'h2; // Control register.
    localparam logic [3:0] OFF_FAULT = 4'h4; // Fault output control.
    localparam logic [3:0] OFF_STOP = 4'h6; // Low-power stop control.
    localparam logic [3:0] OFF_STATUS = 4'h8; // Counter and flags.

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int OPT_MODE_BIT = 1; // Zero selects auto-start mode.
    localparam int OPT_TIMEOUT_FIELD_LSB = 2; // Boot timeout field.
    localparam int OPT_CKS_LSB = 4; // Boot clock divide field.
    localparam int OPT_WINDOW_END_FIELD_LSB = 8; // Boot window end field.
    localparam int OPT_WINDOW_START_FIELD_LSB = 12; // Boot window start field.
    localparam int OPT_STP_BIT = 14; // Boot low-power stop.
    localparam int OPT_RST_BIT = 28; // Boot fault output select.
    localparam int CR_TIMEOUT_FIELD_LSB = 0; // Timeout field.
    localparam int CR_CKS_LSB = 4; // Clock divide field.
    localparam int CR_WINDOW_END_FIELD_LSB = 8; // Window end field.
    localparam int CR_WINDOW_START_FIELD_LSB = 12; // Window start field.
    localparam int FAULT_SEL_BIT = 7; // One selects the reset output.
    localparam int STOP_SEL_BIT = 7; // One stops counting in low power.
    localparam int UF_BIT = 14; // Underflow flag in the status word.
    localparam int RE_BIT = 15; // Refresh error flag.

    // ************************************************************
    // Values, codes and counts.
    // ************************************************************
    localparam logic [15:0] CR_RESET = 16'h33F3; // Control after reset.
    localparam logic [7:0] REFRESH_FIRST = 8'h00; // First refresh byte.
    localparam logic [7:0] REFRESH_SECOND = 8'hFF; // Second byte.
    localparam logic [1:0] BOOT_WAIT = 2'h3; // Cycles before capture.
    localparam logic [13:0] LOAD_L0 = 14'h03FF; // Larger variant.
    localparam logic [13:0] LOAD_L1 = 14'h0FFF;
    localparam logic [13:0] LOAD_L2 = 14'h1FFF;
    localparam logic [13:0] LOAD_L3 = 14'h3FFF;
    localparam logic [13:0] LOAD_S0 = 14'h007F; // Smaller variant.
    localparam logic [13:0] LOAD_S1 = 14'h01FF;
    localparam logic [13:0] LOAD_S2 = 14'h03FF;
    localparam logic [13:0] LOAD_S3 = 14'h07FF;
    localparam logic [3:0] CKS_DIV1 = 4'h0; // Divider codes.
    localparam logic [3:0] CKS_DIV16 = 4'h2;
    localparam logic [3:0] CKS_DIV32 = 4'h3;
    localparam logic [3:0] CKS_DIV64 = 4'h4;
    localparam logic [3:0] CKS_DIV128 = 4'hF;
    localparam logic [3:0] CKS_DIV256 = 4'h5;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [3:0] {
        ST_BOOT = 4'h1, ST_IDLE = 4'h2, ST_COUNT = 4'h4, ST_HALT = 4'h8
    } wdt_fsm_t;

    typedef struct packed {
        logic [3:0] clock_divide_field;
        logic [1:0] timeout_field;
        logic [1:0] window_start_field;
        logic [1:0] window_end_field;
        logic rst_sel;
        logic stp;
    } wdt_cfg_t;

    typedef struct packed {
        wdt_fsm_t fsm;
        logic [1:0] wait_cnt;
        logic clk_s1;
        logic clk_s2;
        logic clk_s3;
        logic [31:0] opt_s1;
        logic [31:0] opt_s2;
        logic auto_mode;
        logic started;
        wdt_cfg_t eff;
        logic [15:0] ctrl;
        logic fault_sel;
        logic stop_sel;
        logic seen_first;
        logic [7:0] pre;
        logic [13:0] cnt;
        logic uf_flag;
        logic re_flag;
        logic [15:0] rdata;
        logic fault_reset;
        logic fault_irq;
        logic counting;
    } wdt_state_t;

    localparam wdt_state_t STATE_RESET = '{
        fsm: ST_BOOT, ctrl: CR_RESET, default: '0
    };

endpackage
`default_nettype wire

// *** test/wdt_properties.sv ***
/*
 * Port-level assertions for the independent watchdog block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`default_nettype none
module wdt_properties (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic wdt_clk_pin,
    input wire logic [31:0] opt_word,
    input wire logic sleep_mode,
    input wire logic sw_standby,
    input wire logic deep_low_power,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [15:0] rdata,
    input wire logic fault_reset,
    input wire logic fault_irq,
    input wire logic counting
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // Helper state.
    // ************************************************************
    logic [2:0] up_r; // Edges since reset release, saturating.
    logic halt_r; // Set once a reset-type fault has halted the block.
    logic low_pwr; // Any low-power request is present.

    assign low_pwr = sleep_mode || sw_standby || deep_low_power;

    // Counts edges after reset and remembers a halting fault.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            up_r <= 3'h0;
            halt_r <= 1'b0;
        end else begin
            if (up_r != 3'h7) up_r <= up_r + 3'h1;
            if (fault_reset) halt_r <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // ************************************************************
    // Assertions.
    // ************************************************************
    chk_fault_exclusive: assert property (
        !(fault_reset && fault_irq))
        else $error("both fault outputs high together");
    chk_reset_pulse: assert property (
        fault_reset |=> !fault_reset)
        else $error("reset fault pulse longer than one cycle");
    chk_irq_pulse: assert property (
        fault_irq |=> !fault_irq)
        else $error("interrupt fault pulse longer than one cycle");
    chk_reset_halts: assert property (
        fault_reset |-> !counting ##1 !counting [*8])
        else $error("counting resumed after reset fault");
    chk_fault_needs_run: assert property (
        (fault_reset || fault_irq) |-> $past(counting))
        else $error("fault raised while not counting");
    chk_refresh_reads: assert property (
        rd_stb && addr == watchdog_pkg::OFF_REFRESH |=> rdata == 16'h0000)
        else $error("refresh register read not zero");
    chk_rdata_idle: assert property (
        !rd_stb |=> rdata == 16'h0000)
        else $error("read data present without a read");
    chk_boot_quiet: assert property (
        up_r <= 3'h3 |-> !counting)
        else $error("counting before option capture");
    chk_auto_start: assert property (
        up_r == 3'h5 && !opt_word[watchdog_pkg::OPT_MODE_BIT] |-> counting)
        else $error("auto-start mode did not start counting");
    chk_refresh_starts: assert property (
        up_r == 3'h7 && !halt_r && !low_pwr && wr_stb
        && addr == watchdog_pkg::OFF_REFRESH && wdata[7:0] == 8'hFF
        && $past(wr_stb && addr == 4'h0 && wdata[7:0] == 8'h00)
        |=> counting || fault_reset || fault_irq)
        else $error("refresh did not start counting");
endmodule
`default_nettype wire

// *** test/tb.sv ***
/*
 * Self-checking testbench of the independent watchdog block.
 * Assumes the package and design are compiled first.
 */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [15:0] exp; logic [15:0] msk;} note_t;
    logic mclk = 1'b0, sys_rst = 1'b1, wdt_clk_pin = 1'b0;
    logic sleep_mode = 1'b0, sw_standby = 1'b0, deep_low_power = 1'b0;
    logic [31:0] opt_word = 32'h0000_0002; // Register start mode.
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic wr_stb = 1'b0, rd_stb = 1'b0, rd_pend = 1'b0;
    logic fault_reset, fault_irq, counting;
    logic [13:0] nn; // Random count of divided periods.
    note_t rq[$]; // Expected read results, oldest first.
    note_t n_w; // Read note taken by the watcher.
    logic [1:0] f_w; // Fault note taken by the watcher.
    logic [1:0] fq[$]; // Expected fault pulses {reset, irq}.
    int err_count = 0, cmp_count = 0, cycles = 0;

    always #5 mclk = ~mclk;

    independent_watchdog_config #(.LARGE_TIMEOUT(1'b1)) dut (
        .mclk(mclk), .sys_rst(sys_rst), .wdt_clk_pin(wdt_clk_pin),
        .opt_word(opt_word), .sleep_mode(sleep_mode),
        .sw_standby(sw_standby), .deep_low_power(deep_low_power),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .fault_reset(fault_reset), .fault_irq(fault_irq),
        .counting(counting));

    // ************************************************************
    // Shared tasks.
    // ************************************************************
    // Compares one value and reports a mismatch.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Holds reset for ten cycles, then waits out the boot.
    task automatic rst_seq();
        sys_rst <= 1'b1;
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask

    // One strobe cycle, then one quiet cycle.
    task automatic bus(input logic w, input logic r, input logic [3:0] a,
                       input logic [15:0] d);
        wr_stb <= w;
        rd_stb <= r;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        @(posedge mclk);
    endtask

    // Reads one register and notes the expected masked value.
    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        rq.push_back('{exp: e, msk: m});
        bus(1'b0, 1'b1, a, 16'h0000);
    endtask

    // Writes the two refresh bytes in consecutive cycles.
    task automatic refresh();
        wr_stb <= 1'b1;
        addr <= watchdog_pkg::OFF_REFRESH;
        wdata <= 16'h0000;
        @(posedge mclk);
        wdata <= 16'h00FF;
        @(posedge mclk);
        wr_stb <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // Gives n watchdog clock periods, two cycles high and two low.
    task automatic ticks(input int n);
        repeat (n) begin
            wdt_clk_pin <= 1'b1;
            repeat (2) @(posedge mclk);
            wdt_clk_pin <= 1'b0;
            repeat (2) @(posedge mclk);
        end
        repeat (6) @(posedge mclk);
    endtask

    // ************************************************************
    // Watcher: read data, fault pulses and the cycle limit.
    // ************************************************************
    always @(posedge mclk) begin
        rd_pend <= rd_stb;
        if (rd_pend && rq.size() > 0) begin
            n_w = rq.pop_front();
            check(rdata & n_w.msk, n_w.exp, "read data");
        end
        // Any fault level other than low is a pulse to account for.
        if (!sys_rst && (fault_reset !== 1'h0 || fault_irq !== 1'h0)) begin
            if (fq.size() == 0) begin
                check({14'h0, fault_reset, fault_irq}, 16'hFFFF,
                      "unexpected fault");
            end else begin
                f_w = fq.pop_front();
                check({14'h0, fault_reset, fault_irq}, {14'h0, f_w},
                      "fault outputs");
            end
        end
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        void'($urandom(32'hccd8));
        rst_seq();
        // Register start mode: reset values, unmapped and refresh reads.
        rd(watchdog_pkg::OFF_CONTROL, watchdog_pkg::CR_RESET,
           16'hFFFF);
        rd(watchdog_pkg::OFF_FAULT, 16'h0000, 16'hFFFF);
        rd(watchdog_pkg::OFF_STOP, 16'h0000, 16'hFFFF);
        rd(4'hA, 16'h0000, 16'hFFFF);
        rd(watchdog_pkg::OFF_REFRESH, 16'h0000, 16'hFFFF);
        // Divide by 16, shortest timeout, window is the last quarter.
        bus(1'b1, 1'b0, watchdog_pkg::OFF_CONTROL, 16'h0320);
        bus(1'b1, 1'b0, watchdog_pkg::OFF_FAULT, 16'h0080);
        bus(1'b1, 1'b0, watchdog_pkg::OFF_STOP, 16'h0080);
        rd(watchdog_pkg::OFF_CONTROL, 16'h0320, 16'hFFFF);
        refresh();
        check({15'h0, counting}, 16'h0001, "counting");
        rd(watchdog_pkg::OFF_STATUS, {2'b00, watchdog_pkg::LOAD_L0},
           16'hFFFF);
        // Settings are locked once counting has started.
        bus(1'b1, 1'b0, watchdog_pkg::OFF_CONTROL, 16'($urandom()));
        rd(watchdog_pkg::OFF_CONTROL, 16'h0320, 16'hFFFF);
        // Each low-power request halts the count when the stop bit is set.
        for (int i = 0; i < 3; i++) begin
            {deep_low_power, sw_standby, sleep_mode} <= 3'h1 << i;
            ticks(32);
            rd(watchdog_pkg::OFF_STATUS, {2'b00, watchdog_pkg::LOAD_L0},
               16'hFFFF);
        end
        {deep_low_power, sw_standby, sleep_mode} <= 3'h0;
        nn = 14'($urandom_range(4, 1));
        ticks(16 * int'(nn));
        rd(watchdog_pkg::OFF_STATUS, {2'b00, watchdog_pkg::LOAD_L0 - nn},
           16'hFFFF);
        // A refresh outside the window raises the reset fault.
        fq.push_back(2'h2);
        refresh();
        repeat (4) @(posedge mclk);
        rd(watchdog_pkg::OFF_STATUS, 16'h8000, 16'hC000);
        check({15'h0, counting}, 16'h0000, "halted");
        check(16'(fq.size()), 16'h0000, "missing faults");
        $display("test register start mode done");
        // Auto-start: divide by 1, shortest timeout, interrupt, no stop.
        opt_word <= 32'h0000_3300;
        sleep_mode <= 1'b1;
        fq.push_back(2'h1);
        rst_seq();
        check({15'h0, counting}, 16'h0001, "auto counting");
        ticks(1024);
        check(16'(fq.size()), 16'h0000, "missing underflow");
        rd(watchdog_pkg::OFF_STATUS, 16'h43FF, 16'hFFFF);
        bus(1'b1, 1'b0, watchdog_pkg::OFF_STATUS, 16'h4000);
        rd(watchdog_pkg::OFF_STATUS, 16'h03FF, 16'hFFFF);
        // Full window: a refresh anywhere in the period reloads the count.
        ticks(4);
        rd(watchdog_pkg::OFF_STATUS, {2'h0, watchdog_pkg::LOAD_L0 - 14'h0004},
           16'hFFFF);
        refresh();
        rd(watchdog_pkg::OFF_STATUS, {2'h0, watchdog_pkg::LOAD_L0},
           16'hFFFF);
        repeat (4) @(posedge mclk);
        $display("test auto-start mode done");
        conclude();
    end
endmodule

bind independent_watchdog_config wdt_properties u_chk (
    .mclk(mclk), .sys_rst(sys_rst), .wdt_clk_pin(wdt_clk_pin),
    .opt_word(opt_word), .sleep_mode(sleep_mode), .sw_standby(sw_standby),
    .deep_low_power(deep_low_power), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fault_reset(fault_reset), .fault_irq(fault_irq), .counting(counting));
`default_nettype wire
